// >>> design/lsm_pkg.sv
// Shared constants and types of the speed-profile and mode block
package lsm_pkg;
    // Register offsets
    localparam logic [7:0] OFS_START = 8'h02;
    localparam logic [7:0] OFS_ACCEL = 8'h03;
    localparam logic [7:0] OFS_DECEL = 8'h04;
    localparam logic [7:0] OFS_TOP = 8'h05;
    localparam logic [7:0] OFS_MID = 8'h06;
    localparam logic [7:0] OFS_BRAKE = 8'h1B;
    localparam logic [7:0] OFS_CFG = 8'h1D;
    localparam logic [7:0] OFS_CURVE_FIRST = 8'h43;
    localparam logic [7:0] OFS_CURVE_LAST = 8'h5E;
    localparam logic [7:0] OFS_CTRL = 8'h80;
    localparam logic [7:0] OFS_KEY_MOM = 8'h81;
    localparam logic [7:0] OFS_KEY_SHUNT = 8'h82;
    localparam logic [7:0] OFS_STATUS = 8'h90;
    localparam logic [7:0] OFS_SPEED = 8'h91;
    // Field positions
    localparam int CFG_CURVE_BIT = 4;
    localparam int BRAKE_DC_BIT = 3;
    localparam int CTRL_DIRBIT = 0;
    // Reset values
    localparam logic [7:0] START_RST = 8'h03;
    localparam logic [7:0] TOP_RST = 8'hFF;
    localparam logic [7:0] MID_RST = 8'h80;
    localparam logic [7:0] RATE_RST = 8'h08;
    localparam logic [7:0] BRAKE_RST = 8'h00;
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [3:0] KEY_MOM_RST = 4'h4;
    localparam logic [3:0] KEY_SHUNT_RST = 4'h3;
    localparam logic [7:0] CURVE_RST_BASE = 8'h01;
    localparam logic [7:0] CURVE_RST_STEP = 8'h09;
    // Fixed end points of the auto-registration table, table size and rate limit
    localparam logic [7:0] CURVE_FIX_FIRST = 8'h01;
    localparam logic [7:0] CURVE_FIX_LAST = 8'hFF;
    localparam int CURVE_PTS = 28;
    localparam logic [7:0] RATE_MAX = 8'h3F;
    // Step-to-position multipliers, 255*256/N rounded up, N the top step 14, 28, 126
    localparam logic [12:0] POS_K14 = 13'h1237;
    localparam logic [12:0] POS_K28 = 13'h091C;
    localparam logic [12:0] POS_K128 = 13'h0207;
    localparam logic [6:0] STEP_MAX14 = 7'h0E;
    localparam logic [6:0] STEP_MAX28 = 7'h1C;
    localparam logic [6:0] STEP_MAX128 = 7'h7E;
    // Timing
    localparam longint CLK_HZ = 20000000;
    localparam longint HOLD_TIME_MS = 4000;
    localparam longint HOLD_CYC = HOLD_TIME_MS * CLK_HZ / 1000;
    localparam longint MOM_UNIT_US = 50;
    localparam logic [15:0] MOM_UNIT_CYC = 16'(MOM_UNIT_US * CLK_HZ / 1000000);
    // Enumerations
    typedef enum logic [1:0] {PR_DCC, PR_TRI, PR_BUS, PR_AUTO} lsm_proto_t;
    typedef enum logic [1:0] {SM_14, SM_28, SM_128} lsm_step_t;
    typedef enum logic [1:0] {TR_DIGITAL, TR_DC, TR_AC} lsm_track_t;
    typedef enum logic [2:0] {
        MD_DIGITAL, MD_DC, MD_DC_BRAKE, MD_AC, MD_REVERSE
    } lsm_mode_t;
endpackage

// >>> design/lsm_speed_mode.sv
// Speed curve, momentum, shunting and track mode switching
// Functional notes
// [RULE1] One key bypasses acceleration and deceleration momentum
// [RULE2] Shunting key halves the commanded speed
// [RULE3] 256 internal steps from 14/28/128 step modes
// [RULE4] Curve bit clear: start, mid, top curve
// [RULE5] User keeps start below mid below top
// [RULE6] Auto-registration variant: start and top only
// [RULE7] Curve bit set: 28-entry user table
// [RULE8] User table ignores start, mid, top
// [RULE9] Variant: table always on, scaled start-top
// [RULE10] Variant: table ends fixed at 1, 255
// [RULE11] DC entry, matching polarity: run on voltage
// [RULE12] DC mismatch: brake if enabled, else reverse
// [RULE13] AC entry: keep direction, voltage sets speed
// [RULE14] Digital entry, matching direction: digital speed
// [RULE15] Mismatch with direction bit: hold direction
// [RULE16] Mismatch without direction bit: stop, reverse, back
// [RULE17] Accept every valid DCC or trinary packet
// [RULE18] Leave bus protocol only after power loss; an auto-registration packet also leaves it
// [RULE19] Switch to auto-registration on its packet
// [RULE20] Leaving auto-registration: four second hold
// [RULE21] Acceleration and deceleration rates 0 to 63
// [RULE22] Linear interpolation between curve points
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module lsm_speed_mode #(
    parameter int unsigned HOLD_CYCLES = 32'(lsm_pkg::HOLD_CYC)
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdata,
    input wire logic autoRegVariant,
    input wire logic pktValid,
    input wire logic [1:0] pktProto,
    input wire logic [6:0] pktStep,
    input wire logic [1:0] pktStepMode,
    input wire logic pktDir,
    input wire logic pktDirChange,
    input wire logic [15:0] funcKeys,
    input wire logic [1:0] trackMode,
    input wire logic dcPolarity,
    input wire logic [7:0] analogLevel,
    input wire logic powerLoss,
    output logic [7:0] motorSpeed,
    output logic motorDir,
    output logic [1:0] activeProto,
    output logic holdActive
);
    typedef struct packed {
        logic [7:0] startLvl;
        logic [7:0] topSpd;
        logic [7:0] midSpd;
        logic [7:0] accel;
        logic [7:0] decel;
        logic [7:0] brakeCfg;
        logic [7:0] cfgFlags;
        logic [7:0] ctrl;
        logic [3:0] keyMom;
        logic [3:0] keyShunt;
        logic [27:0][7:0] curve;
        logic [7:0] rdata;
        logic [7:0] speed;
        logic [15:0] momCnt;
        logic dir;
        lsm_pkg::lsm_mode_t mode;
        lsm_pkg::lsm_proto_t proto;
        logic [26:0] holdCnt;
        logic [6:0] cmdStep;
        lsm_pkg::lsm_step_t cmdMode;
        logic cmdDir;
        logic dirLock;
        logic variant;
        logic varDone;
        lsm_pkg::lsm_track_t prevTrack;
    } lsm_state_t;

    lsm_state_t s_q;
    lsm_state_t s_d;

    // Straight line between two points, fraction in 1/256
    function automatic logic [7:0] lsmLerp(input logic [7:0] lo,
        input logic [7:0] hi, input logic [7:0] f);
        logic signed [9:0] dif;
        logic signed [19:0] prod;
        logic signed [10:0] sum;
        // Full fraction lands exactly on the upper point
        if (f == 8'hFF) begin
            return hi;
        end
        dif = $signed({2'b00, hi}) - $signed({2'b00, lo});
        prod = dif * $signed({2'b00, f});
        sum = $signed({3'b000, lo}) + $signed(prod[18:8]);
        if (sum < 0) begin
            return 8'h00;
        end else if (sum > 11'sd255) begin
            return 8'hFF;
        end
        return sum[7:0];
    endfunction

    // Table entry, with the variant's fixed end points
    function automatic logic [7:0] lsmEntry(input lsm_state_t st,
        input logic [4:0] i);
        if (st.variant && i == 5'd0) begin
            return lsm_pkg::CURVE_FIX_FIRST;
        end else if (st.variant && i == 5'd27) begin
            return lsm_pkg::CURVE_FIX_LAST;
        end
        return st.curve[i];
    endfunction

    logic [12:0] posK;
    logic [19:0] posProd;
    logic [7:0] pos;
    logic [12:0] tblRaw;
    logic [12:0] tblProd;
    logic [4:0] tblIdx;
    logic [7:0] tblVal;
    logic [7:0] curveOut;
    logic [7:0] tgtRaw;
    logic [7:0] tgt;
    logic momOff;
    logic shuntOn;
    logic useTable;
    logic [4:0] curveIdx;
    logic [15:0] rateCyc;

    // Step to internal position 0..255
    // [RULE3] step mode scaling
    assign posK = (s_q.cmdMode == lsm_pkg::SM_14) ? lsm_pkg::POS_K14 :
                  (s_q.cmdMode == lsm_pkg::SM_28) ? lsm_pkg::POS_K28 :
                  lsm_pkg::POS_K128;
    assign posProd = 20'(s_q.cmdStep) * 20'(posK);
    assign pos = (posProd[19:16] != 4'h0) ? 8'hFF : posProd[15:8];

    // Table lookup between neighbouring entries
    // [RULE22] linear between points
    assign tblRaw = 13'(pos) * 13'd27;
    // Stretch by 256/255 so the top step hits the last entry
    assign tblProd = tblRaw + {8'h00, tblRaw[12:8]};
    assign tblIdx = tblProd[12:8];
    assign tblVal = lsmLerp(lsmEntry(s_q, tblIdx),
        lsmEntry(s_q, 5'(tblIdx + 5'd1)), tblProd[7:0]);
    // [RULE9] table always on in variant
    assign useTable = s_q.variant || s_q.cfgFlags[lsm_pkg::CFG_CURVE_BIT];

    // Curve selection
    always_comb begin
        if (s_q.cmdStep == 7'h00) begin
            curveOut = 8'h00;
        end else if (useTable && s_q.variant) begin
            // [RULE6] [RULE9] mid ignored, table scaled
            curveOut = lsmLerp(s_q.startLvl, s_q.topSpd, tblVal);
        end else if (useTable) begin
            // [RULE7] [RULE8] table alone
            curveOut = tblVal;
        end else if (!pos[7]) begin
            // [RULE4] lower half start to mid
            curveOut = lsmLerp(s_q.startLvl, s_q.midSpd, {pos[6:0], 1'b0});
        end else begin
            // [RULE4] upper half mid to top
            curveOut = lsmLerp(s_q.midSpd, s_q.topSpd, {pos[6:0], pos[6]});
        end
    end

    // Function keys and final target
    // [RULE1] momentum bypass key
    assign momOff = funcKeys[s_q.keyMom];
    // [RULE2] shunting key
    assign shuntOn = funcKeys[s_q.keyShunt];
    assign tgtRaw = (s_q.mode == lsm_pkg::MD_DIGITAL) ? curveOut :
                    (s_q.mode == lsm_pkg::MD_DC ||
                     s_q.mode == lsm_pkg::MD_AC) ? analogLevel : 8'h00;
    assign tgt = shuntOn ? {1'b0, tgtRaw[7:1]} : tgtRaw;
    // [RULE21] rate per speed step
    assign rateCyc = 16'((tgt > s_q.speed) ? s_q.accel[5:0] :
        s_q.decel[5:0]) * lsm_pkg::MOM_UNIT_CYC;
    assign curveIdx = 5'(regAddr - lsm_pkg::OFS_CURVE_FIRST);

    // Next state
    always_comb begin
        logic pktTake;
        pktTake = 1'b0;
        s_d = s_q;
        s_d.rdata = 8'h00;
        // Strap captured once after reset release
        if (!s_q.varDone) begin
            s_d.variant = autoRegVariant;
            s_d.varDone = 1'b1;
        end
        // Register writes
        if (regWr) begin
            if (regAddr == lsm_pkg::OFS_START) begin
                s_d.startLvl = regWdata;
            end else if (regAddr == lsm_pkg::OFS_ACCEL) begin
                s_d.accel = (regWdata > lsm_pkg::RATE_MAX) ?
                    lsm_pkg::RATE_MAX : regWdata;
            end else if (regAddr == lsm_pkg::OFS_DECEL) begin
                s_d.decel = (regWdata > lsm_pkg::RATE_MAX) ?
                    lsm_pkg::RATE_MAX : regWdata;
            end else if (regAddr == lsm_pkg::OFS_TOP) begin
                s_d.topSpd = regWdata;
            end else if (regAddr == lsm_pkg::OFS_MID) begin
                s_d.midSpd = regWdata;
            end else if (regAddr == lsm_pkg::OFS_BRAKE) begin
                s_d.brakeCfg = regWdata;
            end else if (regAddr == lsm_pkg::OFS_CFG) begin
                s_d.cfgFlags = regWdata;
            end else if (regAddr >= lsm_pkg::OFS_CURVE_FIRST &&
                         regAddr <= lsm_pkg::OFS_CURVE_LAST) begin
                s_d.curve[curveIdx] = regWdata;
            end else if (regAddr == lsm_pkg::OFS_CTRL) begin
                s_d.ctrl = regWdata;
            end else if (regAddr == lsm_pkg::OFS_KEY_MOM) begin
                s_d.keyMom = regWdata[3:0];
            end else if (regAddr == lsm_pkg::OFS_KEY_SHUNT) begin
                s_d.keyShunt = regWdata[3:0];
            end
        end
        // Register reads, data in the following cycle
        if (regRd) begin
            if (regAddr == lsm_pkg::OFS_START) begin
                s_d.rdata = s_q.startLvl;
            end else if (regAddr == lsm_pkg::OFS_ACCEL) begin
                s_d.rdata = s_q.accel;
            end else if (regAddr == lsm_pkg::OFS_DECEL) begin
                s_d.rdata = s_q.decel;
            end else if (regAddr == lsm_pkg::OFS_TOP) begin
                s_d.rdata = s_q.topSpd;
            end else if (regAddr == lsm_pkg::OFS_MID) begin
                s_d.rdata = s_q.midSpd;
            end else if (regAddr == lsm_pkg::OFS_BRAKE) begin
                s_d.rdata = s_q.brakeCfg;
            end else if (regAddr == lsm_pkg::OFS_CFG) begin
                s_d.rdata = s_q.cfgFlags;
            end else if (regAddr >= lsm_pkg::OFS_CURVE_FIRST &&
                         regAddr <= lsm_pkg::OFS_CURVE_LAST) begin
                // [RULE10] fixed ends read back
                s_d.rdata = lsmEntry(s_q, curveIdx);
            end else if (regAddr == lsm_pkg::OFS_CTRL) begin
                s_d.rdata = s_q.ctrl;
            end else if (regAddr == lsm_pkg::OFS_KEY_MOM) begin
                s_d.rdata = {4'h0, s_q.keyMom};
            end else if (regAddr == lsm_pkg::OFS_KEY_SHUNT) begin
                s_d.rdata = {4'h0, s_q.keyShunt};
            end else if (regAddr == lsm_pkg::OFS_STATUS) begin
                s_d.rdata = {holdActive, s_q.dirLock, s_q.mode,
                    s_q.proto, s_q.dir};
            end else if (regAddr == lsm_pkg::OFS_SPEED) begin
                s_d.rdata = s_q.speed;
            end
        end
        // Protocol arbitration
        if (s_q.holdCnt != 27'h0) begin
            s_d.holdCnt = 27'(s_q.holdCnt - 27'h1);
        end
        if (powerLoss) begin
            // [RULE18] power loss releases bus protocol
            s_d.proto = lsm_pkg::PR_DCC;
            s_d.holdCnt = 27'h0;
        end else if (pktValid) begin
            if (pktProto == lsm_pkg::PR_AUTO) begin
                // [RULE19] immediate switch
                s_d.proto = lsm_pkg::PR_AUTO;
                s_d.holdCnt = 27'h0;
                pktTake = 1'b1;
            end else if (s_q.proto == lsm_pkg::PR_AUTO &&
                         s_q.holdCnt == 27'h0) begin
                // [RULE20] start the hold
                s_d.holdCnt = 27'(HOLD_CYCLES);
                s_d.proto = lsm_lockout_proto(pktProto);
            end else if (s_q.proto == lsm_pkg::PR_BUS &&
                         pktProto != lsm_pkg::PR_BUS) begin
                // [RULE18] stay on bus protocol
                s_d.proto = lsm_pkg::PR_BUS;
            end else if (s_q.holdCnt == 27'h0) begin
                // [RULE17] any valid packet is taken
                s_d.proto = lsm_pkg::lsm_proto_t'(pktProto);
                pktTake = 1'b1;
            end
            // Commands of an accepted packet
            if (pktTake) begin
                s_d.cmdStep = (pktStep > lsm_pkg::STEP_MAX128) ?
                    lsm_pkg::STEP_MAX128 : pktStep;
                s_d.cmdMode = lsm_pkg::lsm_step_t'(pktStepMode);
                s_d.cmdDir = pktDir;
                if (pktDirChange) begin
                    // [RULE15] direction honoured again
                    s_d.dirLock = 1'b0;
                end
            end
        end
        // Track section changes
        s_d.prevTrack = lsm_pkg::lsm_track_t'(trackMode);
        if (trackMode == lsm_pkg::TR_DC &&
            s_q.prevTrack != lsm_pkg::TR_DC) begin
            if (dcPolarity == s_q.dir) begin
                // [RULE11] matching polarity runs on
                s_d.mode = lsm_pkg::MD_DC;
            end else if (s_q.brakeCfg[lsm_pkg::BRAKE_DC_BIT]) begin
                // [RULE12] brake to a stop
                s_d.mode = lsm_pkg::MD_DC_BRAKE;
            end else begin
                // [RULE12] reverse out of section
                s_d.mode = lsm_pkg::MD_DC;
                s_d.dir = dcPolarity;
            end
        end else if (trackMode == lsm_pkg::TR_AC &&
                     s_q.prevTrack != lsm_pkg::TR_AC) begin
            // [RULE13] keep direction
            s_d.mode = lsm_pkg::MD_AC;
        end else if (trackMode == lsm_pkg::TR_DIGITAL &&
                     s_q.prevTrack != lsm_pkg::TR_DIGITAL) begin
            if (s_q.cmdDir == s_q.dir) begin
                // [RULE14] continue digitally
                s_d.mode = lsm_pkg::MD_DIGITAL;
            end else if (s_q.ctrl[lsm_pkg::CTRL_DIRBIT]) begin
                // [RULE15] hold present direction
                s_d.mode = lsm_pkg::MD_DIGITAL;
                s_d.dirLock = 1'b1;
            end else begin
                // [RULE16] stop then reverse
                s_d.mode = lsm_pkg::MD_REVERSE;
            end
        end else begin
            case (s_q.mode)
                lsm_pkg::MD_DIGITAL: begin
                    if (!s_q.dirLock) begin
                        s_d.dir = s_q.cmdDir;
                    end
                end
                lsm_pkg::MD_REVERSE: begin
                    // [RULE16] flip at standstill, drive back
                    if (s_q.speed == 8'h00) begin
                        s_d.dir = !s_q.dir;
                        s_d.dirLock = 1'b1;
                        s_d.mode = lsm_pkg::MD_DIGITAL;
                    end
                end
                default: begin
                end
            endcase
        end
        // Momentum ramp
        if (momOff || rateCyc == 16'h0) begin
            // [RULE1] direct throttle response
            s_d.speed = tgt;
            s_d.momCnt = 16'h0;
        end else if (s_q.speed == tgt) begin
            s_d.momCnt = 16'h0;
        end else if (s_q.momCnt >= 16'(rateCyc - 16'h1)) begin
            // [RULE21] one internal step per period
            s_d.momCnt = 16'h0;
            s_d.speed = (tgt > s_q.speed) ? 8'(s_q.speed + 8'h01) :
                8'(s_q.speed - 8'h01);
        end else begin
            s_d.momCnt = 16'(s_q.momCnt + 16'h1);
        end
    end

    // Protocol taken on as the hold starts: the packet's own
    function automatic lsm_pkg::lsm_proto_t lsm_lockout_proto(
        input logic [1:0] p);
        return lsm_pkg::lsm_proto_t'(p);
    endfunction

    // State register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
            s_q.startLvl <= lsm_pkg::START_RST;
            s_q.topSpd <= lsm_pkg::TOP_RST;
            s_q.midSpd <= lsm_pkg::MID_RST;
            s_q.accel <= lsm_pkg::RATE_RST;
            s_q.decel <= lsm_pkg::RATE_RST;
            s_q.brakeCfg <= lsm_pkg::BRAKE_RST;
            s_q.cfgFlags <= lsm_pkg::CFG_RST;
            s_q.ctrl <= lsm_pkg::CTRL_RST;
            s_q.keyMom <= lsm_pkg::KEY_MOM_RST;
            s_q.keyShunt <= lsm_pkg::KEY_SHUNT_RST;
            for (int i = 0; i < lsm_pkg::CURVE_PTS; i++) begin
                s_q.curve[i] <= 8'(lsm_pkg::CURVE_RST_BASE +
                    8'(i) * lsm_pkg::CURVE_RST_STEP);
            end
            s_q.mode <= lsm_pkg::MD_DIGITAL;
            s_q.proto <= lsm_pkg::PR_DCC;
            s_q.cmdMode <= lsm_pkg::SM_128;
            s_q.prevTrack <= lsm_pkg::TR_DIGITAL;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs
    assign regRdata = s_q.rdata;
    assign motorSpeed = s_q.speed;
    assign motorDir = s_q.dir;
    assign activeProto = s_q.proto;
    assign holdActive = (s_q.holdCnt != 27'h0);

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_revStop;
        s_q.mode == lsm_pkg::MD_REVERSE && s_q.speed == 8'h00 &&
            trackMode == s_q.prevTrack;
    endsequence
    sequence s_revDone;
        s_q.mode == lsm_pkg::MD_DIGITAL && s_q.dirLock;
    endsequence

    property p_momBypass;
        momOff && trackMode == s_q.prevTrack |=> s_q.speed == $past(tgt);
    endproperty
    a_momBypass: assert property (p_momBypass) // [RULE1]
        else $error("bypass did not follow target");
    property p_shunt;
        shuntOn && momOff |=> s_q.speed <= 8'h7F;
    endproperty
    a_shunt: assert property (p_shunt) // [RULE2]
        else $error("shunting speed above half");
    property p_stepTop;
        s_q.cmdStep == lsm_pkg::STEP_MAX14 &&
            s_q.cmdMode == lsm_pkg::SM_14 |-> pos == 8'hFF;
    endproperty
    a_stepTop: assert property (p_stepTop) // [RULE3]
        else $error("top step not full position");
    property p_tableOnly;
        useTable && !s_q.variant && s_q.cmdStep != 7'h00 |->
            curveOut == tblVal;
    endproperty
    a_tableOnly: assert property (p_tableOnly) // [RULE8]
        else $error("table output altered");
    property p_fixedEnd;
        s_q.variant && regRd && regAddr == lsm_pkg::OFS_CURVE_LAST |=>
            regRdata == lsm_pkg::CURVE_FIX_LAST;
    endproperty
    a_fixedEnd: assert property (p_fixedEnd) // [RULE10]
        else $error("last table entry not fixed");
    property p_dcBrake;
        trackMode == lsm_pkg::TR_DC && s_q.prevTrack != lsm_pkg::TR_DC &&
            dcPolarity != s_q.dir &&
            s_q.brakeCfg[lsm_pkg::BRAKE_DC_BIT] |=>
            s_q.mode == lsm_pkg::MD_DC_BRAKE ##1 s_q.speed <= $past(s_q.speed);
    endproperty
    a_dcBrake: assert property (p_dcBrake) // [RULE12]
        else $error("DC mismatch did not brake");
    property p_reverse;
        s_revStop |=> s_revDone ##0 s_q.dir != $past(s_q.dir);
    endproperty
    a_reverse: assert property (p_reverse) // [RULE16]
        else $error("reverse did not complete");
    property p_busStay;
        s_q.proto == lsm_pkg::PR_BUS && pktValid && !powerLoss &&
            pktProto != lsm_pkg::PR_AUTO |=> s_q.proto == lsm_pkg::PR_BUS;
    endproperty
    a_busStay: assert property (p_busStay) // [RULE18]
        else $error("left bus protocol without power loss");
    property p_autoIn;
        pktValid && !powerLoss && pktProto == lsm_pkg::PR_AUTO |=>
            s_q.proto == lsm_pkg::PR_AUTO && !holdActive;
    endproperty
    a_autoIn: assert property (p_autoIn) // [RULE19]
        else $error("no switch to auto-registration");
    property p_hold;
        holdActive && !powerLoss && !(pktValid &&
            pktProto == lsm_pkg::PR_AUTO) |=> $stable(s_q.cmdStep) &&
            $stable(s_q.cmdDir);
    endproperty
    a_hold: assert property (p_hold) // [RULE20]
        else $error("command taken during hold");
endmodule
`default_nettype wire

// >>> testbench/lsm_station_model.sv
// Command station model issuing decoded track packets
`timescale 1ns/1ps
`default_nettype none
module lsm_station_model (
    input wire logic clk,
    input wire logic send,
    input wire logic [12:0] cmd,
    output logic pktValid,
    output logic [12:0] pktBits
);
    // One-cycle packet; fields scramble once released
    initial begin
        pktValid = 1'b0;
        pktBits = 13'h0000;
        forever begin
            @(posedge clk);
            pktValid <= send;
            pktBits <= send ? cmd : ~pktBits;
        end
    end
endmodule
`default_nettype wire

// >>> testbench/testbench.sv
// Self-checking bench of the speed-profile and mode block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk = 1'b0, rst = 1'b1, regWr = 1'b0, regRd = 1'b0, send = 1'b0;
    logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata, motorSpeed;
    logic [7:0] analogLevel = 8'h00;
    logic [15:0] funcKeys = 16'h0000;
    logic [12:0] cmd = 13'h0000, pktBits;
    logic [1:0] trackMode = 2'h0, activeProto;
    logic pktValid, motorDir, holdActive, powerLoss = 1'b0, dcPol = 1'b0;
    logic autoReg = 1'b0;
    int n_errors = 0, checks_done = 0, cyc = 0;
    // Clock of 50 ns
    initial begin
        forever #25 clk = ~clk;
    end
    lsm_station_model i_lsm_station_model (.clk(clk), .send(send),
        .cmd(cmd), .pktValid(pktValid), .pktBits(pktBits));
    lsm_speed_mode #(.HOLD_CYCLES(50)) i_lsm_speed_mode (.clk(clk),
        .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .autoRegVariant(autoReg),
        .pktValid(pktValid), .pktProto(pktBits[12:11]),
        .pktStep(pktBits[10:4]), .pktStepMode(pktBits[3:2]),
        .pktDir(pktBits[1]), .pktDirChange(pktBits[0]),
        .funcKeys(funcKeys), .trackMode(trackMode), .dcPolarity(dcPol),
        .analogLevel(analogLevel), .powerLoss(powerLoss),
        .motorSpeed(motorSpeed), .motorDir(motorDir),
        .activeProto(activeProto), .holdActive(holdActive));
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e,
        input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1 chk("regRdata", e, regRdata);
    endtask
    // Fields: protocol, step, step mode, direction, direction change
    task automatic pkt(input logic [12:0] c);
        @(posedge clk);
        send <= 1'b1;
        cmd <= c;
        @(posedge clk);
        send <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    // Bounded wait for the motor speed to settle
    task automatic spd(input logic [7:0] e);
        int k;
        k = 0;
        #1;
        while (motorSpeed !== e && k < 300) begin
            @(posedge clk) #1;
            k++;
        end
        chk("motorSpeed", e, motorSpeed);
    endtask
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            test_done();
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd(lsm_pkg::OFS_START, 8'h03);
        rd(lsm_pkg::OFS_TOP, 8'hFF);
        rd(lsm_pkg::OFS_MID, 8'h80);
        rd(8'h10, 8'h00);
        wr(lsm_pkg::OFS_ACCEL, 8'hFF);
        rd(lsm_pkg::OFS_ACCEL, lsm_pkg::RATE_MAX);
        wr(lsm_pkg::OFS_DECEL, 8'h00);
        $display("test registers done");
        @(posedge clk);
        funcKeys <= 16'h0010;
        pkt({2'h0, 7'h7E, 2'h2, 2'h0});
        spd(8'hFF);
        @(posedge clk);
        funcKeys <= 16'h0018;
        spd(8'h7F);
        @(posedge clk);
        funcKeys <= 16'h0010;
        trackMode <= 2'h1;
        analogLevel <= 8'h55;
        spd(8'h55);
        @(posedge clk);
        trackMode <= 2'h2;
        analogLevel <= 8'h33;
        spd(8'h33);
        chk("motorDir", 8'h00, {7'h00, motorDir});
        @(posedge clk);
        trackMode <= 2'h0;
        spd(8'hFF);
        wr(lsm_pkg::OFS_BRAKE, 8'h08);
        dcPol <= 1'b1;
        trackMode <= 2'h1;
        spd(8'h00);
        // Opposite command while braked, then back to digital
        pkt({2'h0, 7'h7E, 2'h2, 2'h2});
        trackMode <= 2'h0;
        dcPol <= 1'b0;
        spd(8'hFF);
        chk("motorDir", 8'h01, {7'h00, motorDir});
        $display("test speed and track done");
        wr(lsm_pkg::OFS_TOP, 8'hC0);
        wr(lsm_pkg::OFS_CFG, 8'h10);
        pkt({2'h0, 7'h1C, 2'h1, 2'h1});
        spd(8'hF4);
        chk("motorDir", 8'h00, {7'h00, motorDir});
        pkt({2'h2, 7'h1C, 2'h1, 2'h0});
        pkt({2'h0, 7'h00, 2'h1, 2'h0});
        #1 chk("activeProto", 8'h02, {6'h00, activeProto});
        chk("motorSpeed", 8'hF4, motorSpeed);
        @(posedge clk);
        powerLoss <= 1'b1;
        @(posedge clk);
        powerLoss <= 1'b0;
        pkt({2'h0, 7'h1C, 2'h1, 2'h0});
        #1 chk("activeProto", 8'h00, {6'h00, activeProto});
        pkt({2'h3, 7'h1C, 2'h1, 2'h0});
        #1 chk("activeProto", 8'h03, {6'h00, activeProto});
        pkt({2'h1, 7'h00, 2'h1, 2'h0});
        #1 chk("holdActive", 8'h01, {7'h00, holdActive});
        chk("motorSpeed", 8'hF4, motorSpeed);
        repeat (60) @(posedge clk);
        #1 chk("holdActive", 8'h00, {7'h00, holdActive});
        $display("test curve and protocol done");
        // Restart as the auto-registration variant
        @(posedge clk);
        autoReg <= 1'b1;
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        wr(lsm_pkg::OFS_CURVE_FIRST, 8'h20);
        rd(lsm_pkg::OFS_CURVE_FIRST, lsm_pkg::CURVE_FIX_FIRST);
        rd(lsm_pkg::OFS_CURVE_LAST, lsm_pkg::CURVE_FIX_LAST);
        pkt({2'h0, 7'h0E, 2'h0, 2'h0});
        spd(8'hFF);
        wr(lsm_pkg::OFS_TOP, 8'h80);
        spd(8'h80);
        wr(lsm_pkg::OFS_MID, 8'h10);
        repeat (2) @(posedge clk);
        spd(8'h80);
        $display("test variant done");
        test_done();
    end
endmodule
`default_nettype wire
